// ==== hw/uifl_core.v ====
// Interrupt identification and line format control for one UART channel.
// Assumes an APB master on clk, pending pulses from neighbouring blocks.
//
// Operation
// - Reading identification returns the latched source code, highest-priority pending when latched.
// - A read clears only the reported source; lower ones show next.
// - A reported, unserviced source is not replaced by another.
// - Bits 5..0 encode line, rx data, timeout, tx, modem, flow, handshake.
// - Bit 0 reads 0 when pending, 1 when none; resets to 1.
// - Bits 7 and 6 read 1 when FIFOs on, else 0.
// - Bits 5 and 4 act only with enhanced-function enable set.
// - Flow-off bit stays set until a matching flow-on arrives.
// - Format bit 7 steers accesses to divisor and enhanced register.
// - Format bit 6 holds serial output low for break.
// - Format bit 3 enables parity insertion and checking.
// - Bits 5..4 pick odd, even, forced one or forced zero parity.
// - Bit 2 gives one stop, or 1.5 for 5-bit, else 2.
// - Bits 1..0 give character length 5, 6, 7 or 8.
// - FIFO enable bit turns both FIFOs on; reported in bits 7..6.
`timescale 1ns/10ps
`include "uifl_map.vh"

module uifl_core #(
	parameter NSRC = `UIFL_NSRC
) (
	clk,
	rst,
	psel,
	penable,
	pwrite,
	paddr,
	pwdata,
	prdata,
	pready,
	pslverr,
	src_set,
	src_level,
	flow_on_seen,
	tx_serial_in,
	tx_serial_out,
	char_bits,
	stop_half,
	stop_two,
	parity_en,
	parity_odd,
	parity_force,
	parity_val,
	fifo_enable,
	divisor,
	irq
);
	input  wire            clk;
	input  wire            rst;
	input  wire            psel;
	input  wire            penable;
	input  wire            pwrite;
	input  wire [7:0]      paddr;
	input  wire [31:0]     pwdata;
	output reg  [31:0]     prdata;
	output reg             pready;
	output reg             pslverr;
	input  wire [NSRC-1:0] src_set;      // One-cycle event per source
	input  wire [NSRC-1:0] src_level;    // Sources still asserted (level)
	input  wire            flow_on_seen; // Matching flow-on received
	input  wire            tx_serial_in;
	output reg             tx_serial_out;
	output reg  [3:0]      char_bits;
	output reg             stop_half;
	output reg             stop_two;
	output reg             parity_en;
	output reg             parity_odd;
	output reg             parity_force;
	output reg             parity_val;
	output reg             fifo_enable;
	output reg  [15:0]     divisor;
	output reg             irq;

	reg  [7:0]      line_format_control_r;
	reg  [7:0]      fifo_setup_control_r;
	reg  [7:0]      enhanced_feature_control_r;
	reg  [15:0]     divisor_r;
	reg  [NSRC-1:0] pend_r;
	reg  [NSRC-1:0] pend_nxt;
	reg  [NSRC-1:0] held_r;       // Source latched for reporting
	reg  [NSRC-1:0] held_nxt;
	wire [NSRC-1:0] enabled;
	wire [NSRC-1:0] pick;
	wire            pick_any;
	wire            enh;
	wire            dlab;
	wire            acc;
	wire            wr;
	wire            rd;
	wire            held_any;
	wire            id_busy;      // Identification read in its access phase
	reg  [7:0]      iid_val;
	reg  [31:0]     rdata_nxt;
	reg             hit;

	// Map a one-hot source to its identification code
	function [5:0] id_code;
		input [NSRC-1:0] s;
		begin
			id_code = `UIFL_ID_NONE;
			if (s[`UIFL_SRC_LINE])
				id_code = `UIFL_ID_LINE;
			if (s[`UIFL_SRC_RXDATA])
				id_code = `UIFL_ID_RXDATA;
			if (s[`UIFL_SRC_RXTMO])
				id_code = `UIFL_ID_RXTMO;
			if (s[`UIFL_SRC_TXEMPTY])
				id_code = `UIFL_ID_TXEMPTY;
			if (s[`UIFL_SRC_MODEM])
				id_code = `UIFL_ID_MODEM;
			if (s[`UIFL_SRC_FLOWOFF])
				id_code = `UIFL_ID_FLOWOFF;
			if (s[`UIFL_SRC_HSHAKE])
				id_code = `UIFL_ID_HSHAKE;
		end
	endfunction

	// Address match used by both read and write decode
	function is_addr;
		input [7:0] a;
		input [7:0] b;
		begin
			is_addr = (a == b);
		end
	endfunction

	// APB strobes; every access completes in its second access cycle, after one wait state
	assign acc  = psel && penable && pready;
	assign wr   = acc && pwrite;
	assign rd   = acc && !pwrite;
	assign enh  = enhanced_feature_control_r[`UIFL_EFC_ENH];
	assign dlab = line_format_control_r[`UIFL_LFC_DLAB];

	// enhanced gating
	// Flow-off and handshake sources only count in enhanced mode
	assign enabled = pend_r & {enh, enh, {(NSRC-2){1'b1}}};

	assign held_any = |held_r;

	// No new source is latched while a read of the code is in flight, so
	// the clear always hits the source whose code went onto the bus
	assign id_busy = psel && penable && !pwrite &&
		is_addr(paddr, `UIFL_ADDR_IID) && !dlab;

	uifl_prio #(
		.NSRC(NSRC)
	) u_prio (
		.pend(enabled),
		.any (pick_any),
		.sel (pick)
	);

	// Pending and held-source update
	always @* begin
		pend_nxt = pend_r | src_set;
		held_nxt = held_r;
		// hold reported source
		// Latch a new source only when nothing is being reported, so the
		// code software sees cannot change under its feet.
		if (!held_any && pick_any && !id_busy)
			held_nxt = pick;
		// read clears reported
		// With the divisor bank selected offset 0 is the divisor: no clear.
		// A fresh event of the reported source wins over the clear.
		if (id_busy && pready && held_any) begin
			pend_nxt = (pend_r & ~held_r) | src_set;
			held_nxt = {NSRC{1'b0}};
		end
		// flow-off sticky
		// Flow-off ignores the read clear; only flow-on drops it
		pend_nxt[`UIFL_SRC_FLOWOFF] = (pend_r[`UIFL_SRC_FLOWOFF] &&
			!flow_on_seen) || src_set[`UIFL_SRC_FLOWOFF];
		if (held_r[`UIFL_SRC_FLOWOFF] && !pend_nxt[`UIFL_SRC_FLOWOFF])
			held_nxt = {NSRC{1'b0}};
		// Level sources still asserted stay pending (set wins over clear)
		pend_nxt = pend_nxt | src_level;
	end

	// Identification value shown to a read
	always @* begin
		iid_val[5:0] = held_any ? id_code(held_r) : `UIFL_ID_NONE;
		iid_val[7:6] = {2{fifo_setup_control_r[`UIFL_FSC_FEN]}};
	end

	// Read mux with divisor-latch steering
	always @* begin
		hit       = 1'b1;
		rdata_nxt = `UIFL_BUS_ZERO;
		if (is_addr(paddr, `UIFL_ADDR_IID) && !dlab)
			rdata_nxt[7:0] = iid_val;
		else if (is_addr(paddr, `UIFL_ADDR_IID) && dlab)
			rdata_nxt[15:0] = divisor_r;
		else if (is_addr(paddr, `UIFL_ADDR_LFC))
			rdata_nxt[7:0] = line_format_control_r;
		else if (is_addr(paddr, `UIFL_ADDR_FSC) && !dlab)
			rdata_nxt[7:0] = fifo_setup_control_r;
		else if (is_addr(paddr, `UIFL_ADDR_FSC) && dlab)
			rdata_nxt[7:0] = enhanced_feature_control_r;
		else if (is_addr(paddr, `UIFL_ADDR_PEND))
			rdata_nxt[NSRC-1:0] = pend_r;
		else
			hit = 1'b0;
	end

	// Register writes, interrupt state and bus answer
	always @(posedge clk) begin
		if (rst) begin
			line_format_control_r      <= `UIFL_LFC_RST;
			fifo_setup_control_r       <= `UIFL_FSC_RST;
			enhanced_feature_control_r <= `UIFL_EFC_RST;
			divisor_r                  <= `UIFL_DIV_RST;
			pend_r                     <= {NSRC{1'b0}};
			held_r                     <= {NSRC{1'b0}};
			pready                     <= 1'b0;
			prdata                     <= `UIFL_BUS_ZERO;
			pslverr                    <= 1'b0;
		end else begin
			pend_r <= pend_nxt;
			held_r <= held_nxt;
			// One wait state: ready rises at the end of the first access cycle
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit;
			if (psel && penable && !pready && !pwrite)
				prdata <= rdata_nxt;
			else
				prdata <= `UIFL_BUS_ZERO;
			if (wr && is_addr(paddr, `UIFL_ADDR_LFC))
				line_format_control_r <= pwdata[7:0];
			if (wr && is_addr(paddr, `UIFL_ADDR_IID) && dlab)
				divisor_r <= pwdata[15:0];
			if (wr && is_addr(paddr, `UIFL_ADDR_FSC) && !dlab)
				fifo_setup_control_r <= pwdata[7:0];
			if (wr && is_addr(paddr, `UIFL_ADDR_FSC) && dlab)
				enhanced_feature_control_r <= pwdata[7:0];
		end
	end

	// Format outputs for the serializer, all registered
	always @(posedge clk) begin
		if (rst) begin
			tx_serial_out <= `UIFL_IDLE_HI;
			char_bits     <= `UIFL_CHAR_MIN;
			stop_half     <= 1'b0;
			stop_two      <= 1'b0;
			parity_en     <= 1'b0;
			parity_odd    <= 1'b0;
			parity_force  <= 1'b0;
			parity_val    <= 1'b0;
			fifo_enable   <= 1'b0;
			divisor       <= `UIFL_DIV_RST;
			irq           <= 1'b0;
		end else begin
			tx_serial_out <= tx_serial_in &&
				!line_format_control_r[`UIFL_LFC_BREAK];
			char_bits <= `UIFL_CHAR_MIN + {2'b00,
				line_format_control_r[`UIFL_LFC_LEN_HI:`UIFL_LFC_LEN_LO]};
			stop_half <= line_format_control_r[`UIFL_LFC_STOP] &&
				(line_format_control_r[`UIFL_LFC_LEN_HI:`UIFL_LFC_LEN_LO]
				== 2'b00);
			stop_two <= line_format_control_r[`UIFL_LFC_STOP] &&
				(line_format_control_r[`UIFL_LFC_LEN_HI:`UIFL_LFC_LEN_LO]
				!= 2'b00);
			parity_en <= line_format_control_r[`UIFL_LFC_PEN];
			// shared format
			// Same fields feed transmit and receive so both ends agree
			parity_odd   <= line_format_control_r[`UIFL_LFC_PEN] &&
				!line_format_control_r[`UIFL_LFC_FORCE] &&
				!line_format_control_r[`UIFL_LFC_EVEN];
			parity_force <= line_format_control_r[`UIFL_LFC_PEN] &&
				line_format_control_r[`UIFL_LFC_FORCE];
			parity_val   <= !line_format_control_r[`UIFL_LFC_EVEN];
			fifo_enable <= fifo_setup_control_r[`UIFL_FSC_FEN];
			divisor     <= divisor_r;
			irq <= pick_any;
		end
	end

endmodule // uifl_core

// ==== hw/uifl_map.vh ====
// Register map, field positions and codes for the interrupt identification
// and line format block. Assumes byte addresses on a 32-bit APB.
`ifndef UIFL_MAP_VH
`define UIFL_MAP_VH

// Byte addresses of the registers (one aligned word each)
`define UIFL_ADDR_IID     8'h00
`define UIFL_ADDR_LFC     8'h04
`define UIFL_ADDR_FSC     8'h08
`define UIFL_ADDR_EFC     8'h0C
`define UIFL_ADDR_DIV     8'h10
`define UIFL_ADDR_PEND    8'h14

// Line format, FIFO setup and enhanced feature field positions
`define UIFL_LFC_LEN_LO   0
`define UIFL_LFC_LEN_HI   1
`define UIFL_LFC_STOP     2
`define UIFL_LFC_PEN      3
`define UIFL_LFC_EVEN     4
`define UIFL_LFC_FORCE    5
`define UIFL_LFC_BREAK    6
`define UIFL_LFC_DLAB     7
`define UIFL_FSC_FEN      0
`define UIFL_EFC_ENH      4

// Reset values
`define UIFL_LFC_RST      8'h00
`define UIFL_FSC_RST      8'h00
`define UIFL_EFC_RST      8'h00
`define UIFL_DIV_RST      16'h0001
`define UIFL_CHAR_MIN     4'h5

// Identification codes, bits 5..0
`define UIFL_ID_NONE      6'h01
`define UIFL_ID_LINE      6'h06
`define UIFL_ID_RXDATA    6'h04
`define UIFL_ID_RXTMO     6'h0C
`define UIFL_ID_TXEMPTY   6'h02
`define UIFL_ID_MODEM     6'h00
`define UIFL_ID_FLOWOFF   6'h10
`define UIFL_ID_HSHAKE    6'h20

// Source indexes in the pending vector, highest priority first
`define UIFL_SRC_LINE     0
`define UIFL_SRC_RXDATA   1
`define UIFL_SRC_RXTMO    2
`define UIFL_SRC_TXEMPTY  3
`define UIFL_SRC_MODEM    4
`define UIFL_SRC_FLOWOFF  5
`define UIFL_SRC_HSHAKE   6
`define UIFL_NSRC         7

`define UIFL_IDLE_HI      1'b1
`define UIFL_BUS_ZERO     32'h0000_0000

`endif

// ==== hw/uifl_prio.v ====
// Fixed-priority source picker for the identification register.
// Assumes index 0 is the highest priority; output is combinational.
`timescale 1ns/10ps
`include "uifl_map.vh"

module uifl_prio #(
	parameter NSRC = `UIFL_NSRC
) (
	pend,
	any,
	sel
);
	input  wire [NSRC-1:0] pend;
	output reg             any;
	output reg  [NSRC-1:0] sel;

	integer i;

	// Lowest set index wins; one-hot result
	always @* begin
		any = 1'b0;
		sel = {NSRC{1'b0}};
		for (i = 0; i < NSRC; i = i + 1) begin
			if (pend[i] && !any) begin
				sel[i] = 1'b1;
				any    = 1'b1;
			end
		end
	end

endmodule // uifl_prio

// ==== dv/uifl_core_sva.sv ====
// Checker for the identification and line format block.
// Sees only the ports of uifl_core; bound to it below.
`timescale 1ns/10ps

module uifl_core_chk #(
	parameter NSRC = 7
) (
	input logic            clk,
	input logic            rst,
	input logic            psel,
	input logic            penable,
	input logic            pwrite,
	input logic [7:0]      paddr,
	input logic [31:0]     pwdata,
	input logic [31:0]     prdata,
	input logic            pready,
	input logic            pslverr,
	input logic [NSRC-1:0] src_set,
	input logic            tx_serial_in,
	input logic            tx_serial_out,
	input logic [3:0]      char_bits,
	input logic            stop_half,
	input logic            stop_two,
	input logic            parity_en,
	input logic            parity_odd,
	input logic            parity_force,
	input logic            parity_val,
	input logic            fifo_enable,
	input logic            irq
);
	logic [7:0] lfc_r;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_setup; psel && !penable; endsequence
	sequence s_access; psel && penable && !pready; endsequence
	sequence s_lfc_wr; pready && pwrite && paddr == 8'h04; endsequence
	sequence s_id_rd;
		pready && !pwrite && paddr == 8'h00 && !lfc_r[7];
	endsequence

	// Shadow of the format register; bit 7 tells which bank offset 0 hits
	always @(posedge clk)
		if (rst)
			lfc_r <= 8'h00;
		else if (psel && penable && pready && pwrite && paddr == 8'h04)
			lfc_r <= pwdata[7:0];

	AST_RST: assert property (disable iff (1'b0) rst |=>
		!pready && !irq && tx_serial_out && char_bits == 4'd5)
		else $error("reset state wrong");
	AST_WAIT: assert property (s_setup ##1 s_access |=> pready)
		else $error("no answer after one wait state");
	AST_ONE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_ERR: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	AST_FIFO: assert property (s_id_rd |->
		prdata[31:6] == {24'h0, {2{fifo_enable}}})
		else $error("fifo bits of identification wrong");
	AST_NONE: assert property (s_id_rd ##0 prdata[0] |-> prdata[5:1] == 0)
		else $error("no-pending code malformed");
	AST_LEN: assert property (s_lfc_wr |-> ##2 char_bits == 4'd5 + lfc_r[1:0])
		else $error("character length wrong");
	AST_STOP: assert property (s_lfc_wr |-> ##2
		stop_half == (lfc_r[2] && lfc_r[1:0] == 0)
		&& stop_two == (lfc_r[2] && lfc_r[1:0] != 0))
		else $error("stop length wrong");
	AST_PAR: assert property (s_lfc_wr |-> ##2 parity_en == lfc_r[3] &&
		(!lfc_r[3] || (lfc_r[5] ? parity_force && parity_val == !lfc_r[4]
		: !parity_force && parity_odd == !lfc_r[4])))
		else $error("parity selection wrong");
	AST_BRK: assert property (s_lfc_wr ##0 pwdata[6] |-> ##2 !tx_serial_out)
		else $error("break not forced");
	AST_TXO: assert property (!tx_serial_in |=> !tx_serial_out)
		else $error("serial output not following input");
	AST_IRQ: assert property (|src_set[4:0] |-> ##[1:2] irq)
		else $error("interrupt output not raised");
endmodule // uifl_core_chk

bind uifl_core uifl_core_chk #(.NSRC(NSRC)) u_chk (.*);

// ==== dv/uifl_src_model.sv ====
// Stand-in for the neighbouring blocks: interrupt events, flow-on
// detection and the serializer line. Tasks are entered at a rising edge.
`timescale 1ns/10ps

module uifl_src_model (
	input  logic       clk,
	output logic [6:0] src_set,
	output logic [6:0] src_level,
	output logic       flow_on_seen,
	output logic       tx_serial_in
);
	// Quiet line idles high; no level sources asserted at start
	initial begin
		src_set = 7'h00;
		src_level = 7'h00;
		flow_on_seen = 1'b0;
		tx_serial_in = 1'b1;
	end

	// One-cycle events; bit 7 of the mask is the flow-on notice
	task pulse(input logic [7:0] m);
		src_set <= m[6:0];
		flow_on_seen <= m[7];
		@(posedge clk);
		src_set <= 7'h00;
		flow_on_seen <= 1'b0;
		@(posedge clk);
	endtask

	// Level sources: held until changed, re-set every cycle while high
	task level(input logic [6:0] m);
		src_level <= m;
		@(posedge clk);
	endtask

	// Start bit, eight data bits LSB first, stop bit, one clock each
	task frame(input logic [7:0] d);
		integer i;
		for (i = 0; i < 10; i++) begin
			tx_serial_in <= i == 0 ? 1'b0 : i == 9 ? 1'b1 : d[i-1];
			@(posedge clk);
		end
	endtask
endmodule // uifl_src_model

// ==== dv/test_uifl_core.sv ====
// Self-checking bench for uifl_core over APB.
// Assumes the neighbouring-block model drives the event inputs.
`timescale 1ns/10ps

module test_uifl_core;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] q;
	logic        err;
	wire  [31:0] prdata;
	wire  [15:0] divisor;
	wire  [6:0]  src_set, src_level;
	wire  [3:0]  char_bits;
	wire         pready, pslverr, flow_on_seen, tx_serial_in, tx_serial_out;
	wire         stop_half, stop_two, parity_en, parity_odd, parity_force;
	wire         parity_val, fifo_enable, irq;
	integer      errors = 0;
	integer      checks = 0;
	integer      k;
	logic [5:0]  code [7] = '{6'h06, 6'h04, 6'h0C, 6'h02, 6'h00, 6'h10, 6'h20};

	always #4 clk = ~clk;

	uifl_core u_dut (.*);
	uifl_src_model u_src (.*);

	task results;
		if (errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t got %h want %h", $time, seen, exp);
		end
	endtask

	// One transfer; a missing answer ends the run as a failure
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		integer n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		q = prdata;
		err = pslverr;
		if (pready !== 1'b1) begin
			errors++;
			results();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(q, e);
	endtask

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(8'h00, 32'h01);
		rd(8'h04, 32'h00);
		rd(8'h18, 32'h00);
		check(32'(err), 32'h1);
		// Every value of format bits 5..0; outputs settle two edges after the write
		for (k = 0; k < 64; k++) begin
			apb(1'b1, 8'h04, k);
			repeat (2) @(posedge clk);
			#1;
			check(32'(char_bits), 5 + k[1:0]);
			check({stop_half, stop_two}, {k[2] && !k[1:0], k[2] && k[1:0]});
			check(32'(parity_en), k[3]);
			if (k[3])
				check({parity_force, k[5] ? parity_val : parity_odd}, {k[5], !k[4]});
			@(posedge clk);
			rd(8'h04, k);
		end
		// Break holds the line low even through a stop bit
		apb(1'b1, 8'h04, 32'h40);
		u_src.frame(8'hA5);
		check(32'(tx_serial_out), 32'h0);
		apb(1'b1, 8'h04, 32'h00);
		u_src.frame(8'h3C);
		@(posedge clk);
		check(32'(tx_serial_out), 32'h1);
		// Bank switch reaches divisor and enhanced register
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b1, 8'h04, 32'h80);
		apb(1'b1, 8'h00, 32'h1234);
		apb(1'b1, 8'h08, 32'h10);
		rd(8'h00, 32'h1234);
		check(32'(divisor), 32'h1234);
		apb(1'b1, 8'h04, 32'h00);
		check(32'(fifo_enable), 32'h1);
		rd(8'h00, 32'hC1);
		// Each source alone, then cleared by the read, or for flow-off by a flow-on
		for (k = 0; k < 7; k++) begin
			u_src.pulse(8'h01 << k);
			repeat (3) @(posedge clk);
			check(32'(irq), 32'h1);
			rd(8'h00, {26'h3, code[k]});
			if (k == 5) begin
				rd(8'h00, 32'hD0);
				u_src.pulse(8'h80);
			end
			repeat (3) @(posedge clk);
			rd(8'h00, 32'hC1);
			check(32'(irq), 32'h0);
		end
		// Three at once come out in priority order
		u_src.pulse(8'h19);
		repeat (3) @(posedge clk);
		rd(8'h00, 32'hC6);
		rd(8'h00, 32'hC2);
		rd(8'h00, 32'hC0);
		rd(8'h00, 32'hC1);
		// A held source is not displaced by a later, higher one
		u_src.pulse(8'h08);
		repeat (3) @(posedge clk);
		u_src.pulse(8'h01);
		rd(8'h00, 32'hC2);
		rd(8'h00, 32'hC6);
		// A level source survives the read clear until it drops
		u_src.level(7'h02);
		repeat (3) @(posedge clk);
		rd(8'h00, 32'hC4);
		rd(8'h00, 32'hC4);
		u_src.level(7'h00);
		rd(8'h00, 32'hC4);
		rd(8'h00, 32'hC1);
		// Without the enhanced enable the flow sources stay silent
		apb(1'b1, 8'h04, 32'h80);
		apb(1'b1, 8'h08, 32'h00);
		apb(1'b1, 8'h04, 32'h00);
		u_src.pulse(8'h60);
		repeat (3) @(posedge clk);
		rd(8'h00, 32'hC1);
		rd(8'h14, 32'h60);
		results();
	end
endmodule // test_uifl_core
